// [rps_pkg.sv]
package rps_pkg;
    localparam int NSTAGE = 8;
    localparam int NGROUP = 8;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PS_PER_MS = 1000000000;
    localparam int TS_RES_MS = 1;
    localparam int SAMPLE_PERIOD_MS = 5;
    localparam int MS_CYCLES = TS_RES_MS * (PS_PER_MS / CLK_PERIOD_PS);
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_MS * MS_CYCLES;
    // Frequency in 0.01 Hz, slope and thresholds in 0.01 Hz/s
    localparam int SLOPE_GAIN = 1000 / SAMPLE_PERIOD_MS;
    localparam int HYST_MHZ_S = 100;
    localparam logic [15:0] HYST_UNITS = 16'(HYST_MHZ_S / 10);
    localparam int EVT_DEPTH = 12;
    localparam int NEVT_BITS = 3 * NSTAGE;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MAXRATE = 8'h04;
    localparam logic [7:0] REG_STAGE_EN = 8'h08;
    localparam logic [7:0] REG_FORCE = 8'h0c;
    localparam logic [7:0] REG_CFG_SEL = 8'h10;
    localparam logic [7:0] REG_CFG_A = 8'h14;
    localparam logic [7:0] REG_CFG_LIM = 8'h18;
    localparam logic [7:0] REG_CFG_DLY = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_MEAS = 8'h24;
    localparam logic [7:0] REG_CNT_ST_TR = 8'h28;
    localparam logic [7:0] REG_CNT_BLK = 8'h2c;
    localparam logic [7:0] REG_CNT_CLR = 8'h30;
    localparam logic [7:0] REG_TIME = 8'h34;
    localparam logic [7:0] REG_EVT_PTR = 8'h38;
    localparam logic [7:0] REG_EVT_BASE = 8'h40;

    // Control word fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_REF_LSB = 3;
    localparam int CTRL_FORCE_BIT = 5;
    localparam int CTRL_GROUP_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h00000001;
    localparam logic [15:0] MAXRATE_RST = 16'h07d0;
    localparam logic [15:0] STAGE_EN_RST = 16'h5555;
    localparam logic [15:0] FORCE_RST = 16'h0000;
    // Group settings: {used, f limit, direction[1:0], pick-up[15:0]}
    localparam logic [19:0] CFG_A_RST = 20'h00014;
    localparam logic [15:0] FLO_RST = 16'h1383;
    localparam logic [15:0] FHI_RST = 16'h13ec;
    localparam logic [18:0] DLY_RST = 19'h00014;

    localparam logic [1:0] EN_NO = 2'h1;
    localparam logic [1:0] EN_YES = 2'h2;
    localparam logic [1:0] DIR_RISING = 2'h0;
    localparam logic [1:0] DIR_FALLING = 2'h1;
    localparam logic [1:0] DIR_BOTH = 2'h2;
    localparam logic [1:0] FORCE_NORMAL = 2'h0;
    localparam logic [1:0] FORCE_START = 2'h1;
    localparam logic [1:0] FORCE_TRIP = 2'h2;
    localparam logic [1:0] FORCE_BLOCKED = 2'h3;

    typedef enum logic [2:0] {
        MODE_ON = 3'h1,
        MODE_BLOCKED = 3'h2,
        MODE_TEST = 3'h3,
        MODE_TEST_BLOCKED = 3'h4,
        MODE_OFF = 3'h5
    } rps_mode_t;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_START = 2'b01,
        ST_TRIP = 2'b11,
        ST_BLOCK = 2'b10
    } rps_stage_t;
endpackage

// [rps_slope_protection_block.sv]
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module rps_slope_protection_block #(
    parameter int MS_CYC = rps_pkg::MS_CYCLES,
    parameter int SMP_CYC = rps_pkg::SAMPLE_CYCLES
) (
    input wire logic i_clk_sys, // 200 MHz clock
    input wire logic i_rst, // Async reset, high
    input wire logic [7:0] i_address, // Byte address
    input wire logic i_read, // Avalon read
    input wire logic i_write, // Avalon write
    input wire logic [31:0] i_writedata, // Avalon write data
    output logic [31:0] o_readdata, // Avalon read data
    output logic o_waitrequest, // Avalon waitrequest
    input wire logic [15:0] i_freq_ref0, // Reference 1 frequency, 0.01 Hz
    input wire logic [15:0] i_freq_ref1, // Reference 2 frequency, 0.01 Hz
    input wire logic [15:0] i_freq_ref2, // Reference 3 frequency, 0.01 Hz
    input wire logic [7:0] i_stage_block, // Per-stage blocking input
    output logic [7:0] o_start, // Stage start
    output logic [7:0] o_trip, // Stage trip
    output logic [7:0] o_blocked // Stage blocked
);
    localparam int NS = rps_pkg::NSTAGE;
    localparam int NE = rps_pkg::NEVT_BITS;
    localparam logic signed [25:0] GAIN = 26'(rps_pkg::SLOPE_GAIN);

    logic wait_r;
    logic [31:0] rdata_r;
    logic [31:0] ctrl_r;
    logic [15:0] maxrate_r;
    logic [15:0] stage_en_r;
    logic [15:0] force_r;
    logic [5:0] cfg_sel_r;
    logic [19:0] cfg_a_r [64];
    logic [31:0] cfg_lim_r [64];
    logic [18:0] cfg_dly_r [64];
    logic [31:0] ms_cnt_r;
    logic [31:0] smp_cnt_r;
    logic [31:0] time_ms_r;
    logic tick_d_r;
    logic primed_r;
    logic [15:0] freq_r;
    logic signed [25:0] slope_r;
    logic [NE-1:0] out_r;
    logic [NE-1:0] out_nxt;
    logic [NE-1:0] pend_r;
    logic [25:0] ts_evt_r;
    logic [4:0] scan_r;
    logic [31:0] evt_mem_r [rps_pkg::EVT_DEPTH];
    logic [3:0] wptr_r;
    logic [3:0] evt_cnt_r;
    logic [15:0] cnt_start_r;
    logic [15:0] cnt_trip_r;
    logic [15:0] cnt_blk_r;

    logic req;
    logic wr_en;
    logic [31:0] rd_nxt;
    logic tick_ms;
    logic tick_smp;
    logic [15:0] fsel;
    logic signed [25:0] delta;
    logic signed [25:0] slope_abs;
    logic slope_blk;
    logic [2:0] mode;
    logic [2:0] group;
    logic force_en;
    logic func_blk;
    logic scan_hit;
    logic [1:0] scan_kind;
    logic clr_en;
    logic on_evt;

    assign req = i_read | i_write;
    assign wr_en = i_write & ~wait_r;
    assign mode = ctrl_r[rps_pkg::CTRL_MODE_LSB +: 3];
    assign group = ctrl_r[rps_pkg::CTRL_GROUP_LSB +: 3];
    assign force_en = ctrl_r[rps_pkg::CTRL_FORCE_BIT];
    assign tick_ms = (ms_cnt_r == 32'(MS_CYC - 1));
    assign tick_smp = (smp_cnt_r == 32'(SMP_CYC - 1));
    assign scan_hit = pend_r[scan_r];
    assign scan_kind = scan_r[4:3];
    assign clr_en = wr_en && i_address[7:2] == rps_pkg::REG_CNT_CLR[7:2];
    assign on_evt = scan_hit && out_r[scan_r];

    // One wait cycle per access keeps the read path registered
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else begin
            wait_r <= ~(req & wait_r);
            if (i_read & wait_r) begin
                rdata_r <= rd_nxt;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= rps_pkg::CTRL_RST;
            maxrate_r <= rps_pkg::MAXRATE_RST;
            stage_en_r <= rps_pkg::STAGE_EN_RST;
            force_r <= rps_pkg::FORCE_RST;
            cfg_sel_r <= 6'h00;
        end else if (wr_en) begin
            unique case (i_address[7:2])
                rps_pkg::REG_CTRL[7:2]: ctrl_r <= i_writedata & 32'h0000073f;
                rps_pkg::REG_MAXRATE[7:2]: maxrate_r <= i_writedata[15:0];
                rps_pkg::REG_STAGE_EN[7:2]: stage_en_r <= i_writedata[15:0];
                rps_pkg::REG_FORCE[7:2]: force_r <= i_writedata[15:0];
                rps_pkg::REG_CFG_SEL[7:2]: cfg_sel_r <= i_writedata[5:0];
                default: ;
            endcase
        end
    end

    // Setting groups, indexed {group, stage}
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < 64; k++) begin
                cfg_a_r[k] <= rps_pkg::CFG_A_RST;
                cfg_lim_r[k] <= {rps_pkg::FLO_RST, rps_pkg::FHI_RST};
                cfg_dly_r[k] <= rps_pkg::DLY_RST;
            end
        end else if (wr_en) begin
            if (i_address[7:2] == rps_pkg::REG_CFG_A[7:2]) begin
                cfg_a_r[cfg_sel_r] <= i_writedata[19:0];
            end
            if (i_address[7:2] == rps_pkg::REG_CFG_LIM[7:2]) begin
                cfg_lim_r[cfg_sel_r] <= i_writedata;
            end
            if (i_address[7:2] == rps_pkg::REG_CFG_DLY[7:2]) begin
                cfg_dly_r[cfg_sel_r] <= i_writedata[18:0];
            end
        end
    end

    always_comb begin
        rd_nxt = 32'h00000000;
        if (i_address[7:2] >= rps_pkg::REG_EVT_BASE[7:2]
                && i_address[7:2] < 6'(rps_pkg::REG_EVT_BASE[7:2] + rps_pkg::EVT_DEPTH)) begin
            rd_nxt = evt_mem_r[4'(i_address[7:2] - rps_pkg::REG_EVT_BASE[7:2])];
        end else begin
            unique case (i_address[7:2])
                rps_pkg::REG_CTRL[7:2]: rd_nxt = ctrl_r;
                rps_pkg::REG_MAXRATE[7:2]: rd_nxt = {16'h0000, maxrate_r};
                rps_pkg::REG_STAGE_EN[7:2]: rd_nxt = {16'h0000, stage_en_r};
                rps_pkg::REG_FORCE[7:2]: rd_nxt = {16'h0000, force_r};
                rps_pkg::REG_CFG_SEL[7:2]: rd_nxt = {26'h0000000, cfg_sel_r};
                rps_pkg::REG_CFG_A[7:2]: rd_nxt = {12'h000, cfg_a_r[cfg_sel_r]};
                rps_pkg::REG_CFG_LIM[7:2]: rd_nxt = cfg_lim_r[cfg_sel_r];
                rps_pkg::REG_CFG_DLY[7:2]: rd_nxt = {13'h0000, cfg_dly_r[cfg_sel_r]};
                rps_pkg::REG_STATUS[7:2]: rd_nxt = {7'h00, slope_blk, out_r};
                rps_pkg::REG_MEAS[7:2]: rd_nxt = {slope_r[15:0], freq_r};
                rps_pkg::REG_CNT_ST_TR[7:2]: rd_nxt = {cnt_trip_r, cnt_start_r};
                rps_pkg::REG_CNT_BLK[7:2]: rd_nxt = {16'h0000, cnt_blk_r};
                rps_pkg::REG_TIME[7:2]: rd_nxt = time_ms_r;
                rps_pkg::REG_EVT_PTR[7:2]: rd_nxt = {24'h000000, evt_cnt_r, wptr_r};
                default: rd_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ms_cnt_r <= 32'h00000000;
            time_ms_r <= 32'h00000000;
        end else begin
            ms_cnt_r <= tick_ms ? 32'h00000000 : ms_cnt_r + 32'h00000001;
            if (tick_ms) begin
                time_ms_r <= time_ms_r + 32'h00000001;
            end
        end
    end

    always_comb begin
        unique case (ctrl_r[rps_pkg::CTRL_REF_LSB +: 2])
            2'h1: fsel = i_freq_ref1;
            2'h2: fsel = i_freq_ref2;
            default: fsel = i_freq_ref0;
        endcase
        delta = $signed({10'h000, fsel}) - $signed({10'h000, freq_r});
        slope_abs = slope_r[25] ? -slope_r : slope_r;
    end

    // The first sample has no predecessor, so slope stays zero until then
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            smp_cnt_r <= 32'h00000000;
            tick_d_r <= 1'b0;
            primed_r <= 1'b0;
            freq_r <= 16'h0000;
            slope_r <= 26'sh0000000;
        end else begin
            smp_cnt_r <= tick_smp ? 32'h00000000 : smp_cnt_r + 32'h00000001;
            tick_d_r <= tick_smp;
            if (tick_smp) begin
                primed_r <= 1'b1;
                freq_r <= fsel;
                slope_r <= primed_r ? 26'(delta * GAIN) : 26'sh0000000;
            end
        end
    end

    assign slope_blk = (slope_abs > $signed({10'h000, maxrate_r}));
    assign func_blk = slope_blk || mode == rps_pkg::MODE_BLOCKED
        || mode == rps_pkg::MODE_TEST_BLOCKED;

    generate
        for (genvar g = 0; g < NS; g++) begin : gen_stage
            rps_pkg::rps_stage_t st_r;
            logic [18:0] tmr_r;
            logic pu_rise_r;
            logic pu_fall_r;
            logic pu_rise;
            logic pu_fall;
            logic cond;
            logic active;
            logic blk;
            logic [19:0] cfg_a;
            logic [31:0] lim;
            logic [18:0] dly;
            logic signed [25:0] pk;
            logic signed [25:0] pk_rel;
            logic [1:0] dir;
            logic [1:0] frc;

            assign cfg_a = cfg_a_r[{group, 3'(g)}];
            assign lim = cfg_lim_r[{group, 3'(g)}];
            assign dly = cfg_dly_r[{group, 3'(g)}];
            assign dir = cfg_a[17:16];
            assign frc = force_r[2*g +: 2];
            assign pk = $signed({10'h000, cfg_a[15:0]});
            assign pk_rel = pk - $signed({10'h000, rps_pkg::HYST_UNITS});
            // Pick-up holds until the slope drops by the fixed hysteresis
            assign pu_rise = pu_rise_r ? (slope_r >= pk_rel) : (slope_r >= pk);
            assign pu_fall = pu_fall_r ? (-slope_r >= pk_rel)
                : (-slope_r >= pk);
            assign cond = (dir != rps_pkg::DIR_FALLING && pu_rise
                    && (!cfg_a[18] || freq_r > lim[15:0]))
                || (dir != rps_pkg::DIR_RISING && pu_fall
                    && (!cfg_a[18] || freq_r < lim[31:16]));
            assign active = stage_en_r[2*g +: 2] == rps_pkg::EN_YES && cfg_a[19]
                && mode != rps_pkg::MODE_OFF;
            assign blk = i_stage_block[g] || func_blk;

            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    st_r <= rps_pkg::ST_NORMAL;
                    tmr_r <= 19'h00000;
                    pu_rise_r <= 1'b0;
                    pu_fall_r <= 1'b0;
                end else if (tick_d_r) begin
                    pu_rise_r <= pu_rise;
                    pu_fall_r <= pu_fall;
                    if (!active || !cond) begin
                        st_r <= rps_pkg::ST_NORMAL;
                        tmr_r <= 19'h00000;
                    end else if (blk) begin
                        st_r <= rps_pkg::ST_BLOCK;
                        tmr_r <= 19'h00000;
                    end else begin
                        unique case (st_r)
                            rps_pkg::ST_NORMAL, rps_pkg::ST_BLOCK: begin
                                st_r <= (dly == 19'h00000) ? rps_pkg::ST_TRIP
                                    : rps_pkg::ST_START;
                                tmr_r <= 19'h00001;
                            end
                            rps_pkg::ST_START: begin
                                if (tmr_r >= dly) begin
                                    st_r <= rps_pkg::ST_TRIP;
                                end else begin
                                    tmr_r <= tmr_r + 19'h00001;
                                end
                            end
                            rps_pkg::ST_TRIP: ;
                        endcase
                    end
                end
            end

            always_comb begin
                if (force_en) begin
                    out_nxt[g] = frc == rps_pkg::FORCE_START
                        || frc == rps_pkg::FORCE_TRIP;
                    out_nxt[NS+g] = frc == rps_pkg::FORCE_TRIP;
                    out_nxt[2*NS+g] = frc == rps_pkg::FORCE_BLOCKED;
                end else begin
                    out_nxt[g] = st_r == rps_pkg::ST_START
                        || st_r == rps_pkg::ST_TRIP;
                    out_nxt[NS+g] = st_r == rps_pkg::ST_TRIP;
                    out_nxt[2*NS+g] = st_r == rps_pkg::ST_BLOCK;
                end
            end
        end
    endgenerate

    // Changes are queued and drained by a scanner; a batch shares one time stamp
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            out_r <= '0;
            pend_r <= '0;
            ts_evt_r <= 26'h0000000;
            scan_r <= 5'h00;
        end else begin
            out_r <= out_nxt;
            pend_r <= (pend_r & ~(NE'(scan_hit) << scan_r))
                | (out_nxt ^ out_r);
            if (pend_r == '0 && out_nxt != out_r) begin
                ts_evt_r <= time_ms_r[25:0];
            end
            scan_r <= (scan_r == 5'(NE - 1)) ? 5'h00 : scan_r + 5'h01;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < rps_pkg::EVT_DEPTH; k++) begin
                evt_mem_r[k] <= 32'h00000000;
            end
            wptr_r <= 4'h0;
            evt_cnt_r <= 4'h0;
        end else if (scan_hit) begin
            evt_mem_r[wptr_r] <= {ts_evt_r, scan_r[2:0], scan_kind, out_r[scan_r]};
            wptr_r <= (wptr_r == 4'(rps_pkg::EVT_DEPTH - 1)) ? 4'h0 : wptr_r + 4'h1;
            if (evt_cnt_r != 4'(rps_pkg::EVT_DEPTH)) begin
                evt_cnt_r <= evt_cnt_r + 4'h1;
            end
        end
    end

    // A count arriving with its clear survives as one
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_start_r <= 16'h0000;
            cnt_trip_r <= 16'h0000;
            cnt_blk_r <= 16'h0000;
        end else begin
            if (clr_en && i_writedata[0]) begin
                cnt_start_r <= {15'h0000, on_evt && scan_kind == 2'h0};
            end else if (on_evt && scan_kind == 2'h0) begin
                cnt_start_r <= cnt_start_r + 16'h0001;
            end
            if (clr_en && i_writedata[1]) begin
                cnt_trip_r <= {15'h0000, on_evt && scan_kind == 2'h1};
            end else if (on_evt && scan_kind == 2'h1) begin
                cnt_trip_r <= cnt_trip_r + 16'h0001;
            end
            if (clr_en && i_writedata[2]) begin
                cnt_blk_r <= {15'h0000, on_evt && scan_kind == 2'h2};
            end else if (on_evt && scan_kind == 2'h2) begin
                cnt_blk_r <= cnt_blk_r + 16'h0001;
            end
        end
    end

    assign o_readdata = rdata_r;
    assign o_waitrequest = wait_r;
    assign o_start = out_r[NS-1:0];
    assign o_trip = out_r[2*NS-1:NS];
    assign o_blocked = out_r[NE-1:2*NS];
endmodule // rps_slope_protection_block

// [rps_freq_src.sv]
`timescale 1ns/1ps
module rps_freq_src #(
    parameter int SMP = 100
) (
    input wire logic i_clk_sys, // Clock
    input wire logic i_rst, // Reset
    input wire logic signed [15:0] i_step, // Change per sample period
    output logic [15:0] o_f0, // Reference 1
    output logic [15:0] o_f1, // Reference 2
    output logic [15:0] o_f2 // Reference 3
);
    int cnt;
    // Ramp once per SMP cycles so every sample sees the same difference
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 0;
            o_f0 <= 16'h1388;
        end else if (cnt == SMP - 1) begin
            cnt <= 0;
            o_f0 <= o_f0 + i_step;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // Other phases sit apart so a wrong reference shows
    assign o_f1 = o_f0 + 16'h0064;
    assign o_f2 = o_f0 + 16'h00c8;
endmodule // rps_freq_src

// [rps_chk.sv]
`timescale 1ns/1ps
module rps_chk #(
    parameter int SMP_CYC = 100
) (
    input wire logic i_clk_sys, // Clock
    input wire logic i_rst, // Reset
    input wire logic [7:0] i_address, // Address
    input wire logic i_read, // Read
    input wire logic i_write, // Write
    input wire logic [31:0] i_writedata, // Write data
    input wire logic [31:0] o_readdata, // Read data
    input wire logic o_waitrequest, // Wait
    input wire logic [15:0] i_freq_ref0, // Ref 1
    input wire logic [15:0] i_freq_ref1, // Ref 2
    input wire logic [15:0] i_freq_ref2, // Ref 3
    input wire logic [7:0] i_stage_block, // Block
    input wire logic [7:0] o_start, // Start
    input wire logic [7:0] o_trip, // Trip
    input wire logic [7:0] o_blocked // Blocked
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    int blk_cnt;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) blk_cnt <= 0;
        else if (!i_stage_block[0]) blk_cnt <= 0;
        else if (blk_cnt < SMP_CYC + 4) blk_cnt <= blk_cnt + 1;
    end
    sequence s_req;
        (i_read || i_write) && o_waitrequest;
    endsequence
    sequence s_ans;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    a_one_wait: assert property (s_req |=> s_ans) else $error("bus answer late");
    a_no_stray: assert property (!o_waitrequest |-> $past(i_read || i_write)) else $error("stray answer");
    a_rd_hold: assert property (!(i_read && o_waitrequest) |=> $stable(o_readdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (s_req and i_read && i_address == 8'hfc |=> o_readdata == 0)
        else $error("unmapped read not zero");
    a_trip_has_start: assert property ((o_trip & ~o_start) == 8'h00) else $error("trip without start");
    a_blk_no_start: assert property ((o_blocked & o_start) == 8'h00) else $error("blocked with start");
    a_start_unblocked: assert property ($rose(o_start[0]) |-> !$past(i_stage_block[0], 2))
        else $error("start while blocked");
    a_blk_clears: assert property (blk_cnt == SMP_CYC + 4 |-> !o_start[0])
        else $error("start kept under block");
    a_out_spaced: assert property ($changed({o_start, o_trip, o_blocked}) |=>
        $stable({o_start, o_trip, o_blocked})) else $error("outputs changed twice");
endmodule // rps_chk

// [tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
    localparam int SMP = 100;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [7:0] i_address = 8'h00;
    logic [7:0] i_stage_block = 8'h00;
    logic [31:0] i_writedata = 32'h0;
    logic [31:0] o_readdata, q, q0;
    logic o_waitrequest;
    logic [15:0] i_freq_ref0, i_freq_ref1, i_freq_ref2;
    logic signed [15:0] step = 16'sh0;
    logic [7:0] o_start, o_trip, o_blocked;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 i_clk_sys = ~i_clk_sys;
    rps_freq_src #(.SMP(SMP)) src (.i_clk_sys, .i_rst, .i_step(step), .o_f0(i_freq_ref0),
        .o_f1(i_freq_ref1), .o_f2(i_freq_ref2));
    rps_slope_protection_block #(.MS_CYC(20), .SMP_CYC(SMP)) dut (.i_clk_sys, .i_rst,
        .i_address, .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .i_freq_ref0,
        .i_freq_ref1, .i_freq_ref2, .i_stage_block, .o_start, .o_trip, .o_blocked);
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_read <= !w;
        i_write <= w;
        i_address <= a;
        i_writedata <= d;
        do begin
            @(posedge i_clk_sys);
        end while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // Looked at mid-cycle, then back on the rising edge so later drives stay there
    task automatic outs(input logic [7:0] s, input logic [7:0] t, input logic [7:0] b);
        @(negedge i_clk_sys);
        `CHK({o_start, o_trip, o_blocked}, {s, t, b})
        @(posedge i_clk_sys);
    endtask
    task automatic smp(input int k);
        repeat (k * SMP) @(posedge i_clk_sys);
    endtask
    // Trip must land exactly four evaluations after start, not one early
    task automatic dly_chk;
        for (int n = 0; n < 3 * SMP && o_start[0] !== 1'b1; n++) @(negedge i_clk_sys);
        repeat (4 * SMP - 2) @(negedge i_clk_sys);
        outs(8'h01, 8'h00, 8'h00);
        outs(8'h01, 8'h01, 8'h00);
    endtask
    task automatic t_reset;
        outs(8'h00, 8'h00, 8'h00);
        rd(rps_pkg::REG_CTRL, 32'h1);
        rd(rps_pkg::REG_MAXRATE, 32'h7d0);
        rd(rps_pkg::REG_STAGE_EN, 32'h5555);
        rd(rps_pkg::REG_CFG_A, 32'h14);
        rd(rps_pkg::REG_CFG_LIM, 32'h138313ec);
        rd(rps_pkg::REG_CFG_DLY, 32'h14);
        rd(8'hfc, 32'h0);
    endtask
    task automatic t_instant;
        bus(1'b1, rps_pkg::REG_CFG_SEL, 32'h0);
        bus(1'b1, rps_pkg::REG_CFG_A, 32'h80014);
        bus(1'b1, rps_pkg::REG_CFG_DLY, 32'h0);
        bus(1'b1, rps_pkg::REG_STAGE_EN, 32'h5556);
        step <= 16'sh1;
        smp(3);
        outs(8'h01, 8'h01, 8'h00);
        rd(rps_pkg::REG_EVT_PTR, 32'h22);
        bus(1'b0, rps_pkg::REG_EVT_BASE, 32'h0);
        q0 = q;
        bus(1'b0, rps_pkg::REG_EVT_BASE + 8'h04, 32'h0);
        `CHK(q[31:6], q0[31:6])
        `CHK(q[5:0] + q0[5:0], 6'h04)
        rd(rps_pkg::REG_CNT_ST_TR, 32'h00010001);
    endtask
    task automatic t_dir_block;
        step <= -16'sh1;
        smp(3);
        outs(8'h00, 8'h00, 8'h00);
        bus(1'b1, rps_pkg::REG_CFG_DLY, 32'h4);
        bus(1'b1, rps_pkg::REG_CFG_A, 32'h90014);
        dly_chk();
        i_stage_block <= 8'h01;
        smp(3);
        outs(8'h00, 8'h00, 8'h01);
        i_stage_block <= 8'h00;
        dly_chk();
        smp(1);
        rd(rps_pkg::REG_CNT_BLK, 32'h1);
        bus(1'b1, rps_pkg::REG_CNT_CLR, 32'h7);
        rd(rps_pkg::REG_CNT_BLK, 32'h0);
        rd(rps_pkg::REG_CNT_ST_TR, 32'h0);
    endtask
    // Falling stage, frequency near 49.8 Hz and still falling at -2 Hz/s
    task automatic t_limits;
        bus(1'b1, rps_pkg::REG_CFG_DLY, 32'h0);
        bus(1'b1, rps_pkg::REG_CFG_A, 32'hd0014);
        bus(1'b1, rps_pkg::REG_CFG_LIM, 32'h132413ec);
        smp(2);
        outs(8'h00, 8'h00, 8'h00);
        bus(1'b1, rps_pkg::REG_CFG_LIM, 32'h138313ec);
        smp(2);
        outs(8'h01, 8'h01, 8'h00);
        bus(1'b1, rps_pkg::REG_CTRL, 32'h101);
        smp(2);
        outs(8'h00, 8'h00, 8'h00);
        bus(1'b1, rps_pkg::REG_CTRL, 32'h11);
        smp(2);
        outs(8'h00, 8'h00, 8'h00);
        bus(1'b1, rps_pkg::REG_CTRL, 32'h1);
        smp(3);
        outs(8'h01, 8'h01, 8'h00);
        bus(1'b1, rps_pkg::REG_CFG_A, 32'hd00d2);
        smp(2);
        outs(8'h01, 8'h01, 8'h00);
        bus(1'b1, rps_pkg::REG_CFG_A, 32'hd00d3);
        smp(2);
        outs(8'h00, 8'h00, 8'h00);
        bus(1'b1, rps_pkg::REG_CFG_A, 32'hd00d2);
        smp(2);
        outs(8'h00, 8'h00, 8'h00);
        bus(1'b1, rps_pkg::REG_CFG_A, 32'hd0014);
    endtask
    task automatic t_modes;
        bus(1'b1, rps_pkg::REG_MAXRATE, 32'h64);
        smp(3);
        rd(rps_pkg::REG_STATUS, 32'h01010000);
        bus(1'b1, rps_pkg::REG_MAXRATE, 32'h7d0);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, rps_pkg::REG_CTRL, 32'h21);
            bus(1'b1, rps_pkg::REG_FORCE, 32'(c));
            repeat (4) @(posedge i_clk_sys);
            outs(8'(c == 1 || c == 2), 8'(c == 2), 8'(c == 3));
        end
        for (int m = 1; m < 6; m++) begin
            bus(1'b1, rps_pkg::REG_CTRL, 32'(m));
            smp(6);
            outs(8'(m == 1 || m == 3), 8'(m == 1 || m == 3), 8'(m == 2 || m == 4));
        end
    endtask
    task automatic stop_test;
        if (errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_reset();
        t_instant();
        t_dir_block();
        t_limits();
        t_modes();
        stop_test();
    end
endmodule // tb
bind rps_slope_protection_block rps_chk #(.SMP_CYC(SMP_CYC)) chk (.i_clk_sys, .i_rst,
    .i_address, .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .i_freq_ref0,
    .i_freq_ref1, .i_freq_ref2, .i_stage_block, .o_start, .o_trip, .o_blocked);
